// ==== design/core_pkg.sv ====
// constants, encodings and carriers for the flow, alu and stack core
package core_pkg;
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [15:0] SRAM_TOP_DEF = 16'h7fff;
  localparam int NUM_REGS = 32;
  localparam int SPL_BLOCK_INSTR = 4;
  localparam logic [4:0] MUL_LO = 5'h00;
  localparam logic [4:0] MUL_HI = 5'h01;
  localparam logic [4:0] Z_LO = 5'h1e;
  localparam logic [4:0] Z_HI = 5'h1f;
  // flags register bit positions
  localparam int F_C = 0;
  localparam int F_Z = 1;
  localparam int F_N = 2;
  localparam int F_V = 3;
  localparam int F_S = 4;
  localparam int F_H = 5;
  localparam int F_T = 6;
  localparam int F_I = 7;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  // core locations in i/o space
  localparam logic [5:0] IO_SPL = 6'h3d;
  localparam logic [5:0] IO_SPH = 6'h3e;
  localparam logic [5:0] IO_FLAGS_REGISTER = 6'h3f;
  // opcode fields, bits 15:10
  localparam logic [5:0] OP_CPC = 6'h01;
  localparam logic [5:0] OP_SBC = 6'h02;
  localparam logic [5:0] OP_ADD = 6'h03;
  localparam logic [5:0] OP_CP = 6'h05;
  localparam logic [5:0] OP_SUB = 6'h06;
  localparam logic [5:0] OP_ADC = 6'h07;
  localparam logic [5:0] OP_AND = 6'h08;
  localparam logic [5:0] OP_EOR = 6'h09;
  localparam logic [5:0] OP_OR = 6'h0a;
  localparam logic [5:0] OP_MOV = 6'h0b;
  localparam logic [5:0] OP_MUL = 6'h27;
  localparam logic [5:0] OP_BRBS = 6'h3c;
  localparam logic [5:0] OP_BRBC = 6'h3d;
  // opcode fields, bits 15:12
  localparam logic [3:0] OP_CPI = 4'h3;
  localparam logic [3:0] OP_SBCI = 4'h4;
  localparam logic [3:0] OP_SUBI = 4'h5;
  localparam logic [3:0] OP_ORI = 4'h6;
  localparam logic [3:0] OP_ANDI = 4'h7;
  localparam logic [3:0] OP_RJMP = 4'hc;
  localparam logic [3:0] OP_RELATIVE_CALL_INSTR = 4'hd;
  localparam logic [3:0] OP_LDI = 4'he;
  // one-operand group, bits 15:9 then low nibble
  localparam logic [6:0] OP_ONE = 7'h4a;
  localparam logic [6:0] OP_PUSH = 7'h49;
  localparam logic [6:0] OP_POP = 7'h48;
  localparam logic [3:0] LN_COM = 4'h0;
  localparam logic [3:0] LN_NEG = 4'h1;
  localparam logic [3:0] LN_INC = 4'h3;
  localparam logic [3:0] LN_LSR = 4'h6;
  localparam logic [3:0] LN_DEC = 4'ha;
  localparam logic [3:0] LN_STK = 4'hf;
  localparam logic [2:0] LN_JMP = 3'h6;
  localparam logic [2:0] LN_CALL = 3'h7;
  localparam logic [4:0] OP_IN = 5'h16;
  localparam logic [4:0] OP_OUT = 5'h17;
  localparam logic [7:0] OP_MULS = 8'h02;
  localparam logic [7:0] OP_MULX = 8'h03;
  localparam logic [8:0] OP_BSET = 9'h128;
  localparam logic [8:0] OP_BCLR = 9'h129;
  localparam logic [3:0] LN_BIT = 4'h8;
  localparam logic [15:0] OP_INDIRECT_CALL_INSTR = 16'h9509;
  localparam logic [15:0] OP_RET = 16'h9508;
  localparam logic [15:0] OP_INTERRUPT_RETURN_INSTR = 16'h9518;

  typedef enum logic [6:0] {
    S_EXEC = 7'b0000001,
    S_WORD2 = 7'b0000010,
    S_PUSH_HI = 7'b0000100,
    S_RET1 = 7'b0001000,
    S_RET2 = 7'b0010000,
    S_LOAD = 7'b0100000,
    S_MUL2 = 7'b1000000
  } state_e;

  typedef enum logic [3:0] {
    AO_PASS, AO_ADD, AO_ADC, AO_SUB, AO_SBC, AO_AND, AO_OR, AO_EOR,
    AO_COM, AO_INC, AO_DEC, AO_LSR
  } alu_op_e;

  typedef struct packed {
    logic frac;
    logic a_sgn;
    logic b_sgn;
  } mul_op_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } dm_req_s;
endpackage

// ==== design/mul_unit.sv ====
// two-cycle 8x8 multiplier with signed, unsigned and fractional forms
`timescale 1ns/10ps
module mul_unit (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // operands
  input wire logic start,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire core_pkg::mul_op_s op,
  // result, valid in the cycle after start
  output logic [15:0] product,
  output logic carry
);
  logic signed [8:0] a_x;
  logic signed [8:0] b_x;
  logic signed [17:0] full;
  logic [15:0] raw;

  assign a_x = signed'({op.a_sgn & a[7], a});
  assign b_x = signed'({op.b_sgn & b[7], b});
  assign full = a_x * b_x;
  assign raw = full[15:0];

  // fractional result is shifted left, carry still taken before the shift
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      product <= 16'h0000;
      carry <= 1'b0;
    end else if (start) begin
      product <= op.frac ? {raw[14:0], 1'b0} : raw;
      carry <= raw[15];
    end
  end
endmodule

// ==== design/flow_core.sv ====
// program flow, alu, multiplier, flags and stack machinery of an 8-bit core
`timescale 1ns/10ps
module flow_core #(
  parameter logic [15:0] SRAM_TOP = core_pkg::SRAM_TOP_DEF,
  parameter int BLOCK_INSTR = core_pkg::SPL_BLOCK_INSTR
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // program memory, one cycle read latency
  output logic [15:0] pm_addr,
  input wire logic [15:0] pm_data,
  // data memory and i/o space, one cycle read latency
  output core_pkg::dm_req_s dm_req,
  input wire logic [7:0] dm_rdata,
  // interrupt controller
  input wire logic irq_req,
  input wire logic [15:0] irq_vec,
  output logic irq_ack,
  output logic irq_ret,
  // state seen from outside
  output logic [7:0] flags_register,
  output logic [15:0] stack_top_pointer
);
  core_pkg::state_e state_r, state_nxt;
  logic valid_r;
  logic [15:0] ir_pc_r;
  logic [15:0] sp_r, sp_nxt;
  logic [7:0] flags_r, flags_nxt;
  logic [7:0] tmp_r, tmp_nxt;
  logic [15:0] tgt_r, tgt_nxt;
  logic [2:0] blk_r, blk_nxt;
  logic w2_call_r, w2_call_nxt;
  logic [7:0] rf_r [core_pkg::NUM_REGS];

  // decode of the word on the program bus
  logic [15:0] ir;
  logic [5:0] op6;
  logic [3:0] op4;
  logic [4:0] rd, rr, rdi;
  logic [7:0] kimm;
  logic [5:0] io_a;
  assign ir = pm_data;
  assign op6 = ir[15:10];
  assign op4 = ir[15:12];
  assign rd = ir[8:4];
  assign rr = {ir[9], ir[3:0]};
  assign rdi = {1'b1, ir[7:4]};
  assign kimm = {ir[11:8], ir[3:0]};
  assign io_a = {ir[10:9], ir[3:0]};

  logic is_cmp, is_rr_alu, is_cpi, is_imm_alu, is_ldi, is_mov, is_one, is_neg;
  logic is_push, is_pop, is_in, is_out, is_rjmp, is_relative_call_instr, is_indirect_call_instr;
  logic is_ret, is_interrupt_return_instr, is_word1, is_brb, is_bset, is_bclr;
  logic is_mul, is_muls, is_mulx, is_mul_any, in_core, st_exec, st_word2;
  assign is_cmp = op6 == core_pkg::OP_CP || op6 == core_pkg::OP_CPC;
  assign is_rr_alu = is_cmp || op6 == core_pkg::OP_ADD || op6 == core_pkg::OP_ADC
    || op6 == core_pkg::OP_SUB || op6 == core_pkg::OP_SBC || op6 == core_pkg::OP_AND
    || op6 == core_pkg::OP_OR || op6 == core_pkg::OP_EOR;
  assign is_cpi = op4 == core_pkg::OP_CPI;
  assign is_imm_alu = is_cpi || op4 == core_pkg::OP_SBCI || op4 == core_pkg::OP_SUBI
    || op4 == core_pkg::OP_ORI || op4 == core_pkg::OP_ANDI;
  assign is_ldi = op4 == core_pkg::OP_LDI;
  assign is_mov = op6 == core_pkg::OP_MOV;
  assign is_one = ir[15:9] == core_pkg::OP_ONE && (ir[3:0] == core_pkg::LN_COM
    || ir[3:0] == core_pkg::LN_NEG || ir[3:0] == core_pkg::LN_INC
    || ir[3:0] == core_pkg::LN_LSR || ir[3:0] == core_pkg::LN_DEC);
  assign is_neg = is_one && ir[3:0] == core_pkg::LN_NEG;
  assign is_push = ir[15:9] == core_pkg::OP_PUSH && ir[3:0] == core_pkg::LN_STK;
  assign is_pop = ir[15:9] == core_pkg::OP_POP && ir[3:0] == core_pkg::LN_STK;
  assign is_in = ir[15:11] == core_pkg::OP_IN;
  assign is_out = ir[15:11] == core_pkg::OP_OUT;
  assign in_core = io_a == core_pkg::IO_SPL || io_a == core_pkg::IO_SPH
    || io_a == core_pkg::IO_FLAGS_REGISTER;
  assign is_rjmp = op4 == core_pkg::OP_RJMP;
  assign is_relative_call_instr = op4 == core_pkg::OP_RELATIVE_CALL_INSTR;
  assign is_indirect_call_instr = ir == core_pkg::OP_INDIRECT_CALL_INSTR;
  assign is_ret = ir == core_pkg::OP_RET;
  assign is_interrupt_return_instr = ir == core_pkg::OP_INTERRUPT_RETURN_INSTR;
  assign is_word1 = ir[15:9] == core_pkg::OP_ONE
    && (ir[3:1] == core_pkg::LN_JMP || ir[3:1] == core_pkg::LN_CALL);
  assign is_brb = op6 == core_pkg::OP_BRBS || op6 == core_pkg::OP_BRBC;
  assign is_bset = ir[15:7] == core_pkg::OP_BSET && ir[3:0] == core_pkg::LN_BIT;
  assign is_bclr = ir[15:7] == core_pkg::OP_BCLR && ir[3:0] == core_pkg::LN_BIT;
  assign is_mul = op6 == core_pkg::OP_MUL;
  assign is_muls = ir[15:8] == core_pkg::OP_MULS;
  assign is_mulx = ir[15:8] == core_pkg::OP_MULX;
  assign is_mul_any = is_mul || is_muls || is_mulx;
  assign st_exec = state_r == core_pkg::S_EXEC;
  assign st_word2 = state_r == core_pkg::S_WORD2;

  // operand selection
  logic [4:0] dst;
  logic [7:0] rd_val, rr_val, opa, opb;
  logic [15:0] pc_inc, pc_rel12, pc_rel7, z_ptr;
  assign dst = (is_imm_alu || is_ldi) ? rdi : rd;
  assign rd_val = rf_r[dst];
  assign rr_val = rf_r[rr];
  assign opa = is_neg ? 8'h00 : rd_val;
  assign opb = is_neg ? rd_val : (is_imm_alu ? kimm : rr_val);
  assign pc_inc = ir_pc_r + 16'h0001;
  assign pc_rel12 = pc_inc + {{4{ir[11]}}, ir[11:0]};
  assign pc_rel7 = pc_inc + {{9{ir[9]}}, ir[9:3]};
  assign z_ptr = {rf_r[core_pkg::Z_HI], rf_r[core_pkg::Z_LO]};

  core_pkg::alu_op_e alu_op;
  assign alu_op =
    (op6 == core_pkg::OP_ADD) ? core_pkg::AO_ADD :
    (op6 == core_pkg::OP_ADC) ? core_pkg::AO_ADC :
    (op6 == core_pkg::OP_SUB || op6 == core_pkg::OP_CP || is_neg || is_cpi
      || op4 == core_pkg::OP_SUBI) ? core_pkg::AO_SUB :
    (op6 == core_pkg::OP_SBC || op6 == core_pkg::OP_CPC
      || op4 == core_pkg::OP_SBCI) ? core_pkg::AO_SBC :
    (op6 == core_pkg::OP_AND || op4 == core_pkg::OP_ANDI) ? core_pkg::AO_AND :
    (op6 == core_pkg::OP_OR || op4 == core_pkg::OP_ORI) ? core_pkg::AO_OR :
    (op6 == core_pkg::OP_EOR) ? core_pkg::AO_EOR :
    (is_one && ir[3:0] == core_pkg::LN_COM) ? core_pkg::AO_COM :
    (is_one && ir[3:0] == core_pkg::LN_INC) ? core_pkg::AO_INC :
    (is_one && ir[3:0] == core_pkg::LN_DEC) ? core_pkg::AO_DEC :
    (is_one && ir[3:0] == core_pkg::LN_LSR) ? core_pkg::AO_LSR : core_pkg::AO_PASS;

  logic [7:0] alu_res, alu_flags;
  logic [8:0] sum9;
  logic cin, c_o, h_o, v_o, z_keep, n_o, z_o;
  assign cin = (alu_op == core_pkg::AO_ADC || alu_op == core_pkg::AO_SBC)
    && flags_r[core_pkg::F_C];
  always_comb begin
    sum9 = 9'h000;
    alu_res = opb;
    c_o = flags_r[core_pkg::F_C];
    h_o = flags_r[core_pkg::F_H];
    v_o = 1'b0;
    z_keep = 1'b0;
    case (alu_op)
      core_pkg::AO_ADD, core_pkg::AO_ADC: begin
        sum9 = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
        alu_res = sum9[7:0];
        c_o = sum9[8];
        h_o = opa[3] & opb[3] | opb[3] & ~alu_res[3] | ~alu_res[3] & opa[3];
        v_o = opa[7] & opb[7] & ~alu_res[7] | ~opa[7] & ~opb[7] & alu_res[7];
      end
      core_pkg::AO_SUB, core_pkg::AO_SBC: begin
        sum9 = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
        alu_res = sum9[7:0];
        c_o = sum9[8];
        h_o = ~opa[3] & opb[3] | opb[3] & alu_res[3] | alu_res[3] & ~opa[3];
        v_o = opa[7] & ~opb[7] & ~alu_res[7] | ~opa[7] & opb[7] & alu_res[7];
        // carry chains keep zero so multi-byte compares work
        z_keep = alu_op == core_pkg::AO_SBC;
      end
      core_pkg::AO_AND: alu_res = opa & opb;
      core_pkg::AO_OR: alu_res = opa | opb;
      core_pkg::AO_EOR: alu_res = opa ^ opb;
      core_pkg::AO_COM: begin
        alu_res = ~opa;
        c_o = 1'b1;
      end
      core_pkg::AO_INC: begin
        alu_res = opa + 8'h01;
        v_o = alu_res == 8'h80;
      end
      core_pkg::AO_DEC: begin
        alu_res = opa - 8'h01;
        v_o = alu_res == 8'h7f;
      end
      core_pkg::AO_LSR: begin
        alu_res = {1'b0, opa[7:1]};
        c_o = opa[0];
        v_o = opa[0];
      end
      default: alu_res = opb;
    endcase
  end
  assign n_o = alu_res[7];
  assign z_o = (alu_res == 8'h00) && (!z_keep || flags_r[core_pkg::F_Z]);
  assign alu_flags = {flags_r[core_pkg::F_I:core_pkg::F_T], h_o, n_o ^ v_o, v_o,
    n_o, z_o, c_o};

  // write-back selection
  logic wb_alu, wb_en, alu_upd, br_taken, take_irq, call_go, done;
  logic [7:0] in_val, wb_data, out_val;
  logic [15:0] call_ret, call_tgt, io_addr;
  assign wb_alu = (is_rr_alu && !is_cmp) || (is_imm_alu && !is_cpi) || is_one;
  assign in_val = (io_a == core_pkg::IO_SPL) ? sp_r[7:0] :
    (io_a == core_pkg::IO_SPH) ? sp_r[15:8] : flags_r;
  assign wb_en = wb_alu || is_mov || is_ldi || (is_in && in_core);
  assign wb_data = is_mov ? rr_val : is_ldi ? kimm : is_in ? in_val : alu_res;
  assign alu_upd = is_rr_alu || is_imm_alu || is_one;
  assign out_val = rf_r[rd];
  assign io_addr = {10'h000, io_a};
  assign br_taken = is_brb && (flags_r[ir[2:0]] == (op6 == core_pkg::OP_BRBS));
  assign take_irq = st_exec && valid_r && irq_req && flags_r[core_pkg::F_I]
    && blk_r == 3'h0;
  assign call_go = take_irq || (st_exec && valid_r && (is_relative_call_instr || is_indirect_call_instr))
    || (st_word2 && w2_call_r);
  // interrupt returns to the instruction it displaced, calls to the next one
  assign call_ret = take_irq ? ir_pc_r : pc_inc;
  assign call_tgt = take_irq ? irq_vec : st_word2 ? pm_data : is_indirect_call_instr ? z_ptr : pc_rel12;

  // multiplier
  core_pkg::mul_op_s mul_op;
  logic [7:0] mul_a, mul_b;
  logic [15:0] mul_p;
  logic mul_c, mul_start, mul_wr;
  assign mul_op.frac = is_mulx && (ir[7] || ir[3]);
  assign mul_op.a_sgn = is_muls || (is_mulx && !(!ir[7] && ir[3]));
  assign mul_op.b_sgn = is_muls || (is_mulx && ir[7] && !ir[3]);
  assign mul_a = is_mul ? rf_r[rd] : is_muls ? rf_r[rdi] : rf_r[{2'b10, ir[6:4]}];
  assign mul_b = is_mul ? rr_val : is_muls ? rf_r[{1'b1, ir[3:0]}] : rf_r[{2'b10, ir[2:0]}];
  assign mul_wr = state_r == core_pkg::S_MUL2;

  mul_unit u_mul (
    .clk(clk),
    .arst_n(arst_n),
    .start(mul_start),
    .a(mul_a),
    .b(mul_b),
    .op(mul_op),
    .product(mul_p),
    .carry(mul_c)
  );

  // sequencing; pm_addr is always the word that will sit on pm_data next
  always_comb begin
    state_nxt = state_r;
    pm_addr = ir_pc_r;
    sp_nxt = sp_r;
    flags_nxt = flags_r;
    tmp_nxt = tmp_r;
    tgt_nxt = tgt_r;
    w2_call_nxt = w2_call_r;
    dm_req = '0;
    irq_ack = 1'b0;
    irq_ret = 1'b0;
    mul_start = 1'b0;
    done = 1'b0;
    if (call_go) begin
      dm_req.addr = sp_r;
      dm_req.wdata = call_ret[7:0];
      dm_req.we = 1'b1;
      sp_nxt = sp_r - 16'h0001;
      tmp_nxt = call_ret[15:8];
      tgt_nxt = call_tgt;
      irq_ack = take_irq;
      state_nxt = core_pkg::S_PUSH_HI;
    end else begin
      case (state_r)
        core_pkg::S_EXEC: begin
          if (!valid_r) begin
            pm_addr = core_pkg::RESET_PC;
          end else if (is_word1) begin
            pm_addr = pc_inc;
            w2_call_nxt = ir[1];
            state_nxt = core_pkg::S_WORD2;
          end else if (is_ret || is_interrupt_return_instr || is_pop || (is_in && !in_core)) begin
            dm_req.addr = (is_in && !is_pop) ? io_addr : sp_r + 16'h0001;
            dm_req.re = 1'b1;
            if (!is_in) begin
              sp_nxt = sp_r + 16'h0001;
            end
            state_nxt = (is_ret || is_interrupt_return_instr) ? core_pkg::S_RET1 : core_pkg::S_LOAD;
          end else if (is_mul_any) begin
            mul_start = 1'b1;
            state_nxt = core_pkg::S_MUL2;
          end else begin
            done = 1'b1;
            pm_addr = is_rjmp ? pc_rel12 : br_taken ? pc_rel7 : pc_inc;
            if (is_push) begin
              dm_req.addr = sp_r;
              dm_req.wdata = out_val;
              dm_req.we = 1'b1;
              sp_nxt = sp_r - 16'h0001;
            end
            if (is_out) begin
              if (io_a == core_pkg::IO_SPL) begin
                sp_nxt[7:0] = out_val;
              end else if (io_a == core_pkg::IO_SPH) begin
                sp_nxt[15:8] = out_val;
              end else if (io_a == core_pkg::IO_FLAGS_REGISTER) begin
                flags_nxt = out_val;
              end else begin
                dm_req.addr = io_addr;
                dm_req.wdata = out_val;
                dm_req.we = 1'b1;
              end
            end
            if (is_bset || is_bclr) begin
              flags_nxt[ir[6:4]] = is_bset;
            end
            if (alu_upd) begin
              flags_nxt = alu_flags;
            end
          end
        end
        core_pkg::S_WORD2: begin
          pm_addr = pm_data;
          state_nxt = core_pkg::S_EXEC;
        end
        core_pkg::S_PUSH_HI: begin
          dm_req.addr = sp_r;
          dm_req.wdata = tmp_r;
          dm_req.we = 1'b1;
          sp_nxt = sp_r - 16'h0001;
          pm_addr = tgt_r;
          done = 1'b1;
          state_nxt = core_pkg::S_EXEC;
        end
        core_pkg::S_RET1: begin
          tmp_nxt = dm_rdata;
          dm_req.addr = sp_r + 16'h0001;
          dm_req.re = 1'b1;
          sp_nxt = sp_r + 16'h0001;
          state_nxt = core_pkg::S_RET2;
        end
        core_pkg::S_RET2: begin
          pm_addr = {tmp_r, dm_rdata};
          irq_ret = is_interrupt_return_instr;
          done = 1'b1;
          state_nxt = core_pkg::S_EXEC;
        end
        core_pkg::S_LOAD: begin
          pm_addr = pc_inc;
          done = 1'b1;
          state_nxt = core_pkg::S_EXEC;
        end
        core_pkg::S_MUL2: begin
          pm_addr = pc_inc;
          flags_nxt[core_pkg::F_C] = mul_c;
          flags_nxt[core_pkg::F_Z] = mul_p == 16'h0000;
          done = 1'b1;
          state_nxt = core_pkg::S_EXEC;
        end
        default: state_nxt = core_pkg::S_EXEC;
      endcase
    end
  end

  // a later i/o write ends the block early, the low pointer write itself arms it
  logic spl_wr, io_wr;
  assign io_wr = st_exec && valid_r && !take_irq && is_out;
  assign spl_wr = io_wr && io_a == core_pkg::IO_SPL;
  assign blk_nxt = spl_wr ? 3'(BLOCK_INSTR) : io_wr ? 3'h0 :
    (done && blk_r != 3'h0) ? blk_r - 3'h1 : blk_r;

  // no prescaler: every state advances on each clk edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= core_pkg::S_EXEC;
      valid_r <= 1'b0;
      ir_pc_r <= core_pkg::RESET_PC;
      sp_r <= SRAM_TOP;
      flags_r <= core_pkg::FLAGS_RESET;
      tmp_r <= 8'h00;
      tgt_r <= 16'h0000;
      blk_r <= 3'h0;
      w2_call_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      valid_r <= 1'b1;
      ir_pc_r <= pm_addr;
      sp_r <= sp_nxt;
      flags_r <= flags_nxt;
      tmp_r <= tmp_nxt;
      tgt_r <= tgt_nxt;
      blk_r <= blk_nxt;
      w2_call_r <= w2_call_nxt;
    end
  end

  logic rf_we;
  assign rf_we = st_exec && valid_r && !take_irq && !call_go && wb_en;
  for (genvar i = 0; i < core_pkg::NUM_REGS; i++) begin : g_rf
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        rf_r[i] <= 8'h00;
      end else if (mul_wr && 5'(i) == core_pkg::MUL_LO) begin
        rf_r[i] <= mul_p[7:0];
      end else if (mul_wr && 5'(i) == core_pkg::MUL_HI) begin
        rf_r[i] <= mul_p[15:8];
      end else if (state_r == core_pkg::S_LOAD && 5'(i) == rd) begin
        rf_r[i] <= dm_rdata;
      end else if (rf_we && 5'(i) == dst) begin
        rf_r[i] <= wb_data;
      end
    end
  end

  assign flags_register = flags_r;
  assign stack_top_pointer = sp_r;
endmodule

// ==== tb/core_props.sv ====
// assertions on the flow core ports
`timescale 1ns/10ps
module core_props #(
  parameter logic [15:0] SRAM_TOP = 16'h7fff
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // buses
  input wire logic [15:0] pm_addr,
  input wire logic [15:0] pm_data,
  input wire core_pkg::dm_req_s dm_req,
  input wire logic [15:0] stack_top_pointer
);
  logic first_r;
  wire logic wr = dm_req.we;
  wire logic rd = dm_req.re;
  wire logic [15:0] ad = dm_req.addr;
  wire logic [15:0] sp = stack_top_pointer;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) first_r <= 1'b1;
    else first_r <= 1'b0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_boot_pc; first_r |-> pm_addr == 16'h0000; endproperty
  a_boot_pc: assert property (p_boot_pc) else $error("fetch not at zero");
  property p_boot_sp; first_r |-> sp == SRAM_TOP; endproperty
  a_boot_sp: assert property (p_boot_sp) else $error("sp not at top");
  // ldi after ldi cannot stall, so the fetch must move on
  property p_fetch;
    !first_r && pm_data[15:12] == core_pkg::OP_LDI && $past(pm_data[15:12]) == core_pkg::OP_LDI
      |-> pm_addr == $past(pm_addr) + 16'h1;
  endproperty
  a_fetch: assert property (p_fetch) else $error("no prefetch");
  // first cycle of a multiply refetches its own word, the second moves on
  property p_mul;
    pm_data[15:10] == core_pkg::OP_MUL && !$stable(pm_data)
      |-> pm_addr == $past(pm_addr) ##1 pm_addr == $past(pm_addr) + 16'h1;
  endproperty
  a_mul: assert property (p_mul) else $error("multiply length");
  property p_ret_addr;
    pm_data[15:12] == core_pkg::OP_RELATIVE_CALL_INSTR && wr && !$stable(pm_data)
      |-> dm_req.wdata == 8'($past(pm_addr) + 16'h1)
      ##1 dm_req.wdata == 8'(($past(pm_addr, 2) + 16'h1) >> 8);
  endproperty
  a_ret_addr: assert property (p_ret_addr) else $error("return bytes");
  property p_push1; wr && ad == sp ##1 !wr |-> sp == $past(sp) - 16'h1; endproperty
  a_push1: assert property (p_push1) else $error("push step");
  property p_push2;
    !wr ##1 wr && ad == sp ##1 wr && ad == $past(sp) - 16'h1 |=> sp == $past(sp, 2) - 16'h2;
  endproperty
  a_push2: assert property (p_push2) else $error("two byte push");
  property p_pop_up; rd && ad == sp + 16'h1 |-> ##[1:3] sp > $past(sp); endproperty
  a_pop_up: assert property (p_pop_up) else $error("pop step");
  c_call: cover property (pm_data[15:12] == core_pkg::OP_RELATIVE_CALL_INSTR && wr);
  c_mul: cover property (pm_data[15:10] == core_pkg::OP_MUL);
  c_pop: cover property (rd);
endmodule
bind flow_core core_props #(.SRAM_TOP(SRAM_TOP)) props (.clk(clk), .arst_n(arst_n),
  .pm_addr(pm_addr), .pm_data(pm_data), .dm_req(dm_req), .stack_top_pointer(stack_top_pointer));

// ==== tb/mem_model.sv ====
// program and data memory seen by the core
`timescale 1ns/10ps
module mem_model (
  // clock
  input wire logic clk,
  // program side
  input wire logic [15:0] pm_addr,
  output logic [15:0] pm_data,
  // data side
  input wire core_pkg::dm_req_s dm_req,
  output logic [7:0] dm_rdata
);
  logic [15:0] rom [0:31];
  logic [7:0] ram [0:255];
  initial dm_rdata = 8'h00;
  always @(posedge clk) begin
    pm_data <= rom[pm_addr[4:0]];
    // idle cycles flip the data, so a stale byte is never trusted
    dm_rdata <= dm_req.re ? ram[dm_req.addr[7:0]] : ~dm_rdata;
    if (dm_req.we) ram[dm_req.addr[7:0]] <= dm_req.wdata;
  end
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the flow core
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] pm_addr, pm_data, sp, p;
  logic [7:0] dm_rdata, flags, a, b, s, f;
  logic [8:0] c;
  logic [4:0] hc;
  logic v;
  core_pkg::dm_req_s dm_req;
  logic [23:0] exp_q[$];
  logic [23:0] got;
  int n_fail = 0;
  int checks_done = 0;
  int seed = 54048;
  int n_wr = 0;
  flow_core #(.SRAM_TOP(16'h00ff)) dut (.clk(clk), .arst_n(arst_n), .pm_addr(pm_addr),
    .pm_data(pm_data), .dm_req(dm_req), .dm_rdata(dm_rdata), .irq_req(1'b0),
    .irq_vec(16'h0000), .irq_ack(), .irq_ret(), .flags_register(flags),
    .stack_top_pointer(sp));
  mem_model mem (.clk(clk), .pm_addr(pm_addr), .pm_data(pm_data), .dm_req(dm_req),
    .dm_rdata(dm_rdata));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic cmp(input logic [23:0] g, input logic [23:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // every data write is matched against the oldest note
  always @(posedge clk) begin
    if (arst_n && dm_req.we === 1'b1) begin
      n_wr++;
      got = {dm_req.addr, dm_req.wdata};
      cmp(got, exp_q.size() > 0 ? exp_q.pop_front() : ~got);
    end
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      arst_n <= 1'b0;
      a = i ? 8'($random(seed)) : 8'h80;
      b = i ? 8'($random(seed)) : 8'h80;
      s = a + b;
      c = {1'b0, a} + {1'b0, b};
      hc = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      v = (a[7] == b[7]) && (s[7] != a[7]);
      f = {2'b00, hc[4], s[7] ^ v, v, s[7], s == 8'h00, c[8]};
      p = 16'(s) * 16'(b);
      // stack ends at 0x00fd, two below its reset top, inside sram
      mem.rom = '{0: {4'he, a[7:4], 4'h0, a[3:0]}, 1: {4'he, b[7:4], 4'h1, b[3:0]},
        2: 16'h0f01, 3: 16'hb73f, 4: 16'h933f, 5: 16'h930f, 7: 16'hd003, 8: 16'h912f,
        9: 16'h932f, 10: 16'hcfff, 11: 16'h9f01, 12: 16'h920f, 13: 16'h921f,
        14: 16'h901f, 15: 16'h900f, 16: 16'h9508, default: 16'h0000};
      exp_q = '{{16'h00ff, f}, {16'h00fe, s}, {16'h00fd, 8'h08}, {16'h00fc, 8'h00},
        {16'h00fb, p[7:0]}, {16'h00fa, p[15:8]}, {16'h00fe, s}};
      n_wr = 0;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      for (int k = 0; k < 300 && n_wr < 7; k++) @(posedge clk);
      if (n_wr < 7) begin
        n_fail++;
        break;
      end
      repeat (2) @(posedge clk);
      @(negedge clk);
      cmp({8'h00, sp}, 24'h0000fd);
      cmp(24'(exp_q.size()), 24'h000000);
      cmp({16'h0000, flags}, {16'h0000, f[7:2], p == 16'h0000, p[15]});
      $display("test %0d done", i);
    end
    stop_test();
  end
endmodule
